// >>> mcbd_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Network controller writing command words
module mcbd_ctrl_model
(
  input  wire logic          sys_clk_in,  // Clock
  input  wire logic [15:0]   rd_data_in,  // Read data
  output mcbd_pkg::mcbd_wr_t wr_out,      // Register writes
  output logic      [15:0]   rd_addr_out  // Read address
);
  import mcbd_pkg::*;
  initial wr_out = '0;
  initial rd_addr_out = 16'hffff;
  // One write; idle bus shows inverted values, never stale ones
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == 16'h0401) ? (d & ~16'h004d) : d;
    @(posedge sys_clk_in);
    wr_out <= '{1'b1, a, v};
    @(posedge sys_clk_in);
    wr_out <= '{1'b0, ~a, ~v};
  endtask
  // Registered read, data one cycle after the address
  task automatic get(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    rd_addr_out <= a;
    @(posedge sys_clk_in);
    #1 d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// >>> mcbd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "mcbd_regs.svh"
module mcbd_decoder
(
  input  wire logic                sys_clk_in,       // System clock
  input  wire logic                rst_n_in,         // Sync reset, low
  input  wire mcbd_pkg::mcbd_wr_t  wr_in,            // Network register write
  input  wire logic [15:0]         rd_addr_in,       // Network register read address
  output logic      [15:0]         rd_data_out,      // Read data
  input  wire logic                flash_done_in,    // Flash write finished
  input  wire logic                flash_ok_in,      // Flash write succeeded
  input  wire logic                motion_busy_in,   // Profile engine moving
  output logic                     move_valid_out,   // One-cycle launch pulse
  output mcbd_pkg::mcbd_move_t     move_out,         // Launch parameters
  output logic                     cur_update_out,   // Live current update pulse
  output logic      [15:0]         cur_value_out,    // Live current value
  output logic                     save_move_out,    // Persist assembled move pulse
  output logic                     save_offset_out,  // Persist encoder offset pulse
  output logic                     led_green_out,    // Move save succeeded indicator
  output logic                     led_red_out,      // Move save failed indicator
  output logic                     locked_out,       // Locked until power cycle
  output logic                     ack_out,          // Offset stored acknowledge
  output logic                     param_err_out     // Last launch was out of range
);
  import mcbd_pkg::*;

  typedef enum logic [3:0] {
    MCBD_IDLE   = 4'b0001,
    MCBD_SAVING = 4'b0010,
    MCBD_OFFSET = 4'b0100,
    MCBD_LOCKED = 4'b1000
  } mcbd_state_t;

  // ========================================================
  // Command block storage
  logic [15:0] words_q [0:9];
  logic [3:0]  wr_idx;
  logic        wr_hit;
  logic [3:0]  rd_idx;
  logic        rd_hit;

  // Address decode; anything outside 1024..1033 is dropped or reads zero
  assign wr_idx = wr_in.addr[3:0];
  assign wr_hit = wr_in.wr && (wr_in.addr >= `MCBD_ADDR_PRIMARY)
                  && (wr_in.addr <= `MCBD_ADDR_JERK);
  assign rd_idx = rd_addr_in[3:0];
  assign rd_hit = (rd_addr_in >= `MCBD_ADDR_PRIMARY)
                  && (rd_addr_in <= `MCBD_ADDR_JERK);

  // Writes are frozen once locked, so nothing can provoke more flash traffic
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `MCBD_WORD_COUNT; i++)
        words_q[i] <= `MCBD_ZERO16;
    end
    else if (wr_hit && !locked_out)
      words_q[wr_idx] <= wr_in.data;
  end

  // Readback registered, so data out comes from a flip-flop
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      rd_data_out <= `MCBD_ZERO16;
    else
      rd_data_out <= rd_hit ? words_q[rd_idx] : `MCBD_ZERO16;
  end

  // ========================================================
  // Field extraction
  logic [15:0] prim;
  logic [15:0] opt;
  logic [31:0] pos32;
  logic [31:0] spd32;

  // Join a word pair, upper word in the high half
  function automatic logic [31:0] join_pair(input logic [15:0] up, input logic [15:0] lo);
    join_pair = {up, lo};
  endfunction

  // Signed 24-bit step range check on a joined value
  function automatic logic pos_ok(input logic [31:0] v);
    pos_ok = ($signed(v) >= $signed(`MCBD_POS_MIN))
             && ($signed(v) <= $signed(`MCBD_POS_MAX));
  endfunction

  // Motor current window, shared by launch and live update paths
  function automatic logic cur_in_range(input logic [15:0] v);
    cur_in_range = (v >= `MCBD_CUR_MIN) && (v <= `MCBD_CUR_MAX);
  endfunction

  // Acceleration and deceleration window
  function automatic logic rate_ok(input logic [15:0] v);
    rate_ok = (v >= `MCBD_RATE_MIN) && (v <= `MCBD_RATE_MAX);
  endfunction

  assign prim  = words_q[0];
  assign opt   = words_q[1];
  assign pos32 = join_pair(words_q[2], words_q[3]);
  assign spd32 = join_pair(words_q[4], words_q[5]);

  // ========================================================
  // Edge detection on the primary word
  logic [15:0] rise;
  logic [15:0] fall;

  mcbd_edge u_edge
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .level_in   (prim),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // ========================================================
  // Command decode
  logic go_abs;
  logic go_rel;
  logic go_hold;
  logic go_resume;
  logic go_stop;
  logic go_jog_cw;
  logic go_jog_ccw;
  logic launch;
  logic uses_pos;
  logic uses_rates;
  logic cur_ovr;
  logic range_ok;
  logic cur_ok;

  // Only zero-to-one transitions launch; stop wins over the rest
  assign go_stop    = |(rise & `MCBD_CMD_STOP);
  assign go_hold    = |(rise & `MCBD_CMD_HOLD) && !go_stop;
  assign go_resume  = |(rise & `MCBD_CMD_RESUME) && !go_stop;
  assign go_abs     = |(rise & `MCBD_CMD_ABS) && !go_stop;
  assign go_rel     = |(rise & `MCBD_CMD_REL) && !go_stop;
  assign go_jog_cw  = rise[`MCBD_BIT_JOG_CW] && !go_stop;
  assign go_jog_ccw = rise[`MCBD_BIT_JOG_CCW] && !go_stop;
  assign launch     = go_stop | go_hold | go_resume | go_abs | go_rel
                      | go_jog_cw | go_jog_ccw;

  assign uses_pos   = go_abs | go_rel;
  assign uses_rates = uses_pos | go_resume | go_jog_cw | go_jog_ccw;
  assign cur_ovr    = opt[`MCBD_OPT_CUR_OVR];

  // Range checks apply only to words the command actually uses
  assign cur_ok   = !cur_ovr || cur_in_range(words_q[8]);
  assign range_ok = (!uses_pos || pos_ok(pos32))
                    && (!uses_rates || ((spd32 <= `MCBD_SPD_MAX)
                    && rate_ok(words_q[6]) && rate_ok(words_q[7])
                    && (words_q[9] <= `MCBD_RATE_MAX) && cur_ok));

  // ========================================================
  // Move request register
  mcbd_move_t move_d;

  // Unused speed, rate, jerk and current words are masked to zero; an unused position keeps its last value
  always_comb
  begin
    move_d              = move_out;
    move_d.abs_move     = go_abs;
    move_d.rel_move     = go_rel;
    move_d.hold         = go_hold;
    move_d.resume       = go_resume;
    move_d.stop         = go_stop;
    move_d.jog_cw       = go_jog_cw;
    move_d.jog_ccw      = go_jog_ccw;
    move_d.registration = opt[`MCBD_OPT_REG_MOVE];
    move_d.ccw_blend    = opt[`MCBD_OPT_BLEND_REV];
    move_d.cur_override = cur_ovr;
    // Resume keeps the held target; only abs and rel carry one
    move_d.position     = uses_pos ? pos32 : move_out.position;
    move_d.speed        = uses_rates ? spd32 : '0;
    move_d.accel        = uses_rates ? words_q[6] : `MCBD_ZERO16;
    move_d.decel        = uses_rates ? words_q[7] : `MCBD_ZERO16;
    move_d.jerk         = uses_rates ? words_q[9] : `MCBD_ZERO16;
    move_d.current      = (uses_rates && cur_ovr) ? words_q[8] : `MCBD_ZERO16;
  end

  logic launch_ok;
  assign launch_ok = launch && range_ok && !locked_out;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      move_out       <= '0;
      move_valid_out <= 1'b0;
      param_err_out  <= 1'b0;
    end
    else
    begin
      move_valid_out <= launch_ok;
      if (launch_ok)
        move_out <= move_d;
      if (launch && !locked_out)
        param_err_out <= !range_ok;
    end
  end

  // ========================================================
  // Live current update while a move runs with override held
  logic cur_wr;
  assign cur_wr = wr_hit && (wr_in.addr == `MCBD_ADDR_CURRENT) && cur_ovr
                  && motion_busy_in && !locked_out
                  && cur_in_range(wr_in.data);

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_update_out <= 1'b0;
      cur_value_out  <= `MCBD_ZERO16;
    end
    else
    begin
      cur_update_out <= cur_wr;
      if (cur_wr)
        cur_value_out <= wr_in.data;
    end
  end

  // ========================================================
  // Persist sequencing
  mcbd_state_t state_q;
  mcbd_state_t state_d;
  logic        persist;
  logic        save_move_req;
  logic        save_off_req;

  assign persist       = opt[`MCBD_OPT_PERSIST];
  // Program strobe falling with persist high asks for a save
  assign save_move_req = fall[`MCBD_BIT_PROGRAM] && persist;
  assign save_off_req  = rise[`MCBD_BIT_ENC_PRESET] && persist;
  assign locked_out    = (state_q == MCBD_LOCKED);

  // Offset save returns to idle; move save locks until reset
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MCBD_IDLE:
      begin
        if (save_move_req)
          state_d = MCBD_SAVING;
        else if (save_off_req)
          state_d = MCBD_OFFSET;
      end
      MCBD_SAVING:
      begin
        if (flash_done_in)
          state_d = MCBD_LOCKED;
      end
      MCBD_OFFSET:
      begin
        if (flash_done_in)
          state_d = MCBD_IDLE;
      end
      MCBD_LOCKED:
        state_d = MCBD_LOCKED;   // Only power cycle (reset) leaves
      default:
        state_d = MCBD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q         <= MCBD_IDLE;
      save_move_out   <= 1'b0;
      save_offset_out <= 1'b0;
      led_green_out   <= 1'b0;
      led_red_out     <= 1'b0;
      ack_out         <= 1'b0;
    end
    else
    begin
      state_q         <= state_d;
      save_move_out   <= (state_q == MCBD_IDLE) && save_move_req;
      save_offset_out <= (state_q == MCBD_IDLE) && !save_move_req
                         && save_off_req;
      if ((state_q == MCBD_SAVING) && flash_done_in)
      begin
        led_green_out <= flash_ok_in;
        led_red_out   <= !flash_ok_in;
      end
      // Acknowledge holds until the next preset request
      if ((state_q == MCBD_OFFSET) && flash_done_in)
        ack_out <= flash_ok_in;
      else if (save_off_req && (state_q == MCBD_IDLE))
        ack_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> mcbd_decoder_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checks on the command decoder
module mcbd_decoder_monitor
(
  input wire logic                 sys_clk_in,     // Clock
  input wire logic                 rst_n_in,       // Reset, low
  input wire mcbd_pkg::mcbd_wr_t   wr_in,          // Writes
  input wire logic                 flash_done_in,  // Flash done
  input wire logic                 flash_ok_in,    // Flash ok
  input wire logic                 motion_busy_in, // Moving
  input wire logic                 move_valid_out, // Launch
  input wire mcbd_pkg::mcbd_move_t move_out,       // Launch data
  input wire logic                 cur_update_out, // Live current
  input wire logic [15:0]          cur_value_out,  // Live value
  input wire logic                 save_move_out,  // Save move
  input wire logic                 locked_out,     // Locked
  input wire logic                 ack_out         // Offset ack
);
  import mcbd_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Primary word write seen at an edge
  wire w0 = wr_in.wr && wr_in.addr == 16'h0400;
  // ==========================================
  // Properties
  property p_cause; move_valid_out |-> $past(w0, 2); endproperty
  property p_stop; move_valid_out && move_out.stop |-> !(move_out.abs_move
    || move_out.rel_move || move_out.resume); endproperty
  property p_keep; move_valid_out && move_out.resume |->
    move_out.position == $past(move_out.position); endproperty
  property p_cur0; move_valid_out && !move_out.cur_override |->
    move_out.current == 16'h0000; endproperty
  property p_pos; move_valid_out && (move_out.abs_move || move_out.rel_move) |->
    (&move_out.position[31:23]) || !(|move_out.position[31:23]); endproperty
  property p_live; cur_update_out |-> $past(motion_busy_in)
    && cur_value_out inside {[16'h000a:16'h0036]}; endproperty
  property p_save; save_move_out |-> $past(w0 && !wr_in.data[12], 2); endproperty
  property p_lock; locked_out |=> locked_out && !move_valid_out; endproperty
  property p_ack; $rose(ack_out) |-> $past(flash_done_in && flash_ok_in); endproperty
  a_cause: assert property (p_cause)
    else $error("launch without primary write");
  a_stop: assert property (p_stop)
    else $error("stop launched with other moves");
  a_keep: assert property (p_keep)
    else $error("resume changed target");
  a_cur0: assert property (p_cur0)
    else $error("current passed without override");
  a_pos: assert property (p_pos)
    else $error("position out of range");
  a_live: assert property (p_live)
    else $error("bad live current update");
  a_save: assert property (p_save)
    else $error("save without strobe fall");
  a_lock: assert property (p_lock)
    else $error("lock released or launch while locked");
  a_ack: assert property (p_ack)
    else $error("ack without good flash write");
  // Main scenarios reached
  c_resume: cover property (move_valid_out && move_out.resume);
  c_live: cover property (cur_update_out);
  c_lock: cover property (locked_out);
endmodule
`default_nettype wire

// >>> mcbd_edge.sv
`timescale 1ns/1ns
`default_nettype none
`include "mcbd_regs.svh"
// ==========================================================
// Rising and falling edge finder for the bits of the primary word
module mcbd_edge
(
  input  wire logic        sys_clk_in,  // System clock
  input  wire logic        rst_n_in,    // Sync reset, low
  input  wire logic [15:0] level_in,    // Current command word
  output logic      [15:0] rise_out,    // Zero-to-one bits
  output logic      [15:0] fall_out     // One-to-zero bits
);
  logic [15:0] prev_q;

  // Previous word; reset to zero, so a bit already set after reset fires as a rise
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      prev_q <= `MCBD_ZERO16;
    else
      prev_q <= level_in;
  end

  // Edge wires
  assign rise_out = level_in & ~prev_q;
  assign fall_out = ~level_in & prev_q;
endmodule
`default_nettype wire

// >>> mcbd_pkg.sv
`default_nettype none
package mcbd_pkg;
  // Register write port
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] data;
  } mcbd_wr_t;
  // Move request to the profile engine
  typedef struct packed {
    logic        abs_move;
    logic        rel_move;
    logic        hold;
    logic        resume;
    logic        stop;
    logic        jog_cw;
    logic        jog_ccw;
    logic        registration;
    logic        ccw_blend;
    logic        cur_override;
    logic [31:0] position;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
  } mcbd_move_t;
endpackage
`default_nettype wire

// >>> mcbd_regs.svh
`ifndef MCBD_REGS_SVH
`define MCBD_REGS_SVH
// ==========================================================
// Register addresses (network register numbers)
`define MCBD_ADDR_PRIMARY   16'h0400
`define MCBD_ADDR_OPTIONS   16'h0401
`define MCBD_ADDR_POS_UP    16'h0402
`define MCBD_ADDR_POS_LO    16'h0403
`define MCBD_ADDR_SPD_UP    16'h0404
`define MCBD_ADDR_SPD_LO    16'h0405
`define MCBD_ADDR_ACCEL     16'h0406
`define MCBD_ADDR_DECEL     16'h0407
`define MCBD_ADDR_CURRENT   16'h0408
`define MCBD_ADDR_JERK      16'h0409
`define MCBD_WORD_COUNT     4'ha
// ==========================================================
// Primary word command bits
`define MCBD_CMD_ABS        16'h0001
`define MCBD_CMD_REL        16'h0002
`define MCBD_CMD_HOLD       16'h0004
`define MCBD_CMD_RESUME     16'h0008
`define MCBD_CMD_STOP       16'h0010
`define MCBD_BIT_JOG_CW     7
`define MCBD_BIT_JOG_CCW    8
`define MCBD_BIT_PROGRAM    12
`define MCBD_BIT_ENC_PRESET 14
// ==========================================================
// Option word bits
`define MCBD_OPT_REG_MOVE   7
`define MCBD_OPT_PERSIST    5
`define MCBD_OPT_BLEND_REV  4
`define MCBD_OPT_CUR_OVR    1
`define MCBD_OPT_RSVD_MASK  16'h004d
// ==========================================================
// Value ranges
`define MCBD_POS_MIN        32'hff80_0000
`define MCBD_POS_MAX        32'h007f_ffff
`define MCBD_SPD_MAX        32'h002d_c6bf
`define MCBD_RATE_MIN       16'h0001
`define MCBD_RATE_MAX       16'h1388
`define MCBD_CUR_MIN        16'h000a
`define MCBD_CUR_MAX        16'h0036
`define MCBD_ZERO16         16'h0000
`endif

// >>> motion_command_block_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Decoder testbench
module motion_command_block_decoder_tb;
  import mcbd_pkg::*;
  logic        clk, rst_n, fdone, fok, busy, val, cupd, smv, soff, grn, red, lck, ack, perr;
  logic [15:0] rd_addr, rd_data, cval, rd;
  mcbd_wr_t    wr;
  mcbd_move_t  mv;
  int          errors = 0;
  int          samples_checked = 0;
  mcbd_decoder dut (.sys_clk_in(clk), .rst_n_in(rst_n), .wr_in(wr), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .flash_done_in(fdone), .flash_ok_in(fok), .motion_busy_in(busy),
    .move_valid_out(val), .move_out(mv), .cur_update_out(cupd), .cur_value_out(cval),
    .save_move_out(smv), .save_offset_out(soff), .led_green_out(grn), .led_red_out(red),
    .locked_out(lck), .ack_out(ack), .param_err_out(perr));
  mcbd_ctrl_model u_ctrl (.sys_clk_in(clk), .rd_data_in(rd_data), .wr_out(wr),
    .rd_addr_out(rd_addr));
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Legal block: top speed, edge rates
  task automatic blk(input logic [15:0] o, input logic [31:0] p, input logic [15:0] c);
    u_ctrl.put(16'h0401, o);
    u_ctrl.put(16'h0402, p[31:16]);
    u_ctrl.put(16'h0403, p[15:0]);
    u_ctrl.put(16'h0404, 16'h002d);
    u_ctrl.put(16'h0405, 16'hc6bf);
    u_ctrl.put(16'h0406, 16'h0001);
    u_ctrl.put(16'h0407, 16'h1388);
    u_ctrl.put(16'h0408, c);
    u_ctrl.put(16'h0409, 16'h1388);
  endtask
  // Zero then command, sample the cycle after
  task automatic go(input logic [15:0] w);
    u_ctrl.put(16'h0400, 16'h0000);
    u_ctrl.put(16'h0400, w);
    @(posedge clk);
    #1;
  endtask
  task automatic flash(input logic ok);
    @(posedge clk);
    fdone <= 1'b1;
    fok <= ok;
    @(posedge clk);
    fdone <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    u_ctrl.get(16'h0402, rd);
    chk("reset word", 16'h0000, rd);
    blk(16'h0002, 32'h1234_5678, 16'h0020);
    u_ctrl.put(16'h040a, 16'h5a5a);
    u_ctrl.get(16'h0403, rd);
    chk("pos lower", 16'h5678, rd);
    u_ctrl.get(16'h0409, rd);
    chk("jerk", 16'h1388, rd);
    u_ctrl.get(16'h040a, rd);
    chk("unmapped", 16'h0000, rd);
  endtask
  task automatic t_moves;
    blk(16'h0002, 32'h007f_ffff, 16'h0036);
    go(16'h0001);
    chk("abs", 2'b11, {val, mv.abs_move});
    chk("abs pos", 32'h007f_ffff, mv.position);
    chk("speed", 32'h002d_c6bf, mv.speed);
    chk("cur", 16'h0036, mv.current);
    chk("rates", {16'h0001, 16'h1388}, {mv.accel, mv.decel});
    chk("jerk out", 16'h1388, mv.jerk);
    blk(16'h0000, 32'hff80_0000, 16'h0036);
    go(16'h0002);
    chk("rel", 2'b11, {val, mv.rel_move});
    chk("rel pos", 32'hff80_0000, mv.position);
    chk("cur off", 16'h0000, mv.current);
    blk(16'h0000, 32'h0080_0000, 16'h0036);
    go(16'h0001);
    chk("over range", 2'b01, {val, perr});
  endtask
  task automatic t_hold;
    blk(16'h0000, 32'h0000_1000, 16'h0020);
    go(16'h0001);
    blk(16'h0000, 32'h0000_2000, 16'h0020);
    go(16'h0004);
    chk("hold", 2'b11, {val, mv.hold});
    chk("hold speed", 32'h0, mv.speed);
    go(16'h0008);
    chk("resume", 2'b11, {val, mv.resume});
    chk("held pos", 32'h0000_1000, mv.position);
    chk("resume speed", 32'h002d_c6bf, mv.speed);
    go(16'h0011);
    chk("stop", 3'b110, {val, mv.stop, mv.abs_move});
  endtask
  task automatic t_opts;
    for (int i = 0; i < 2; i++)
    begin
      blk(i ? 16'h0090 : 16'h0000, 32'h0, 16'h0020);
      go(i ? 16'h0100 : 16'h0080);
      chk("jog", i ? 3'b101 : 3'b110, {val, mv.jog_cw, mv.jog_ccw});
      chk("reg", i, mv.registration);
      chk("blend", i, mv.ccw_blend);
    end
  endtask
  task automatic t_live;
    blk(16'h0002, 32'h0000_0100, 16'h0020);
    go(16'h0001);
    busy <= 1'b1;
    u_ctrl.put(16'h0408, 16'h001e);
    #1;
    chk("live", 17'h1001e, {cupd, cval});
    u_ctrl.put(16'h0408, 16'h0037);
    #1;
    chk("live bad", 17'h0001e, {cupd, cval});
    busy <= 1'b0;
  endtask
  task automatic t_persist;
    blk(16'h0020, 32'h0, 16'h0020);
    go(16'h4000);
    chk("save offset", 1'b1, soff);
    flash(1'b1);
    chk("ack", 1'b1, ack);
    u_ctrl.put(16'h0400, 16'h1000);
    u_ctrl.put(16'h0400, 16'h0000);
    @(posedge clk);
    #1;
    chk("save move", 1'b1, smv);
    flash(1'b0);
    chk("leds lock", 3'b011, {grn, red, lck});
    go(16'h0001);
    chk("locked launch", 1'b0, val);
    u_ctrl.get(16'h0400, rd);
    chk("locked word", 16'h0000, rd);
  endtask
  // Power cycle clears the lock; stop needs no range checks
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    go(16'h0010);
    chk("power cycle", 3'b101, {val, lck, mv.stop});
  endtask
  task automatic conclude;
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Clock, sequence, watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    fdone = 1'b0;
    fok = 1'b0;
    busy = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_moves();
    t_hold();
    t_opts();
    t_live();
    t_persist();
    t_reset();
    conclude();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule
bind mcbd_decoder mcbd_decoder_monitor u_mon (.sys_clk_in, .rst_n_in, .wr_in, .flash_done_in,
  .flash_ok_in, .motion_busy_in, .move_valid_out, .move_out, .cur_update_out, .cur_value_out,
  .save_move_out, .locked_out, .ack_out);
`default_nettype wire
